// ===== verilog/ebp_bus.sv
// external parallel bus pin controller with avalon register port
//
// Behaviour
// RQ1 - low sixteen address lines every access; upper seven only for program
// RQ2 - address outputs float in hold mode and while float input is low
// RQ3 - host wide select high turns low address lines into host inputs
// RQ4 - sixteen-bit two-way data bus shared by all spaces
// RQ5 - data drivers off unless writing, and during reset or hold request
// RQ6 - data bus floats whenever float input is low
// RQ7 - enabled keepers hold each undriven data pin at its last level
// RQ8 - keepers reset disabled; software toggles them in bank control
// RQ9 - interrupt ack low while vector address is on low address lines
// RQ10 - interrupt ack output floats while float input is low
// RQ11 - hold request granted by floating lines and asserting grant
// RQ12 - ready sampled after two or more wait states, retried each cycle
// RQ13 - read-not-write high except during an external write
// RQ14 - memory strobe low only for data or program accesses; the code also asserts it for the unused space code 3
// RQ15 - float input overrides every other drive decision; bus_keeper_enable is not gated by it
`timescale 1ns/1ns
module ebp_bus
	import ebp_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic [AV_AW-1:0]  avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	input  wire logic [LO_W-1:0]   addr_lo_i,
	output logic      [LO_W-1:0]   addr_lo_o,
	output logic                   addr_lo_oe,
	output logic      [HI_W-1:0]   addr_hi_o,
	output logic                   addr_hi_oe,
	input  wire logic [DATA_W-1:0] data_i,
	output logic      [DATA_W-1:0] data_o,
	output logic                   data_oe,
	output logic                   bus_keeper_enable,
	output logic                   read_write_n,
	output logic                   memory_strobe_n,
	output logic                   io_strobe_n,
	output logic                   ctl_oe,
	input  wire logic              bus_hold_n,
	output logic                   bus_grant_n,
	output logic                   bus_grant_oe,
	input  wire logic              ready,
	output logic                   interrupt_ack_n,
	output logic                   interrupt_ack_oe,
	input  wire logic              float_all_n,
	input  wire logic              host_port_wide_select,
	output logic      [LO_W-1:0]   host_port_addr
);

	////////////////////////////////////////////////////////////////////
	localparam int SW = 4 + LO_W + DATA_W;
	localparam logic [SW-1:0] SYNC_INIT = {4'hA, {(LO_W+DATA_W){1'b0}}};

	typedef struct packed {
		ebp_fsm_t          fsm;
		logic [WC_W-1:0]   ws_cnt;
		logic [WS_W-1:0]   ws_cfg;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] rdata;
		logic [DATA_W-1:0] keep_val;
		logic [1:0]        space;
		logic              wr;
		logic              vec;
		logic              keep_en;
		logic              avs_wait;
		logic [31:0]       rbus;
		logic [LO_W-1:0]   alo;
		logic [HI_W-1:0]   ahi;
		logic              alo_oe;
		logic              ahi_oe;
		logic [DATA_W-1:0] dout;
		logic              d_oe;
		logic              kp_en;
		logic              rw_n;
		logic              memory_strobe_n_n;
		logic              iostrb_n;
		logic              ctl_oe;
		logic              grant_n;
		logic              grant_oe;
		logic              interrupt_ack_n_n;
		logic              interrupt_ack_n_oe;
		logic [LO_W-1:0]   hp_addr;
	} ebp_st_t;

	ebp_st_t           q;
	ebp_st_t           d;
	logic [SW-1:0]     sync_out;
	logic              hold_s;
	logic              ready_s;
	logic              off_s;
	logic              hw_s;
	logic [LO_W-1:0]   alo_s;
	logic [DATA_W-1:0] data_s;
	logic [31:0]       rd_val;
	logic [31:0]       bmask;
	logic [31:0]       wmerge;
	logic              wr_take;
	logic              start;
	logic              acc_d;

	////////////////////////////////////////////////////////////////////
	// every pin input crosses two flops before use
	ebp_sync #(
		.W    (SW),
		.INIT (SYNC_INIT)
	) u_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.din     ({bus_hold_n, ready, float_all_n,
		           host_port_wide_select, addr_lo_i, data_i}),
		.dout    (sync_out)
	);

	assign {hold_s, ready_s, off_s, hw_s, alo_s, data_s} = sync_out;

	////////////////////////////////////////////////////////////////////
	// register readback, also the base for byte-lane merging
	always_comb begin
		rd_val = '0;
		case (avs_address)
		REG_BSC:   rd_val[BSC_KEEP_BIT] = q.keep_en;
		REG_WAIT:  rd_val[WS_W-1:0] = q.ws_cfg;
		REG_ADDR:  rd_val[ADDR_W-1:0] = q.addr;
		REG_WDATA: rd_val[DATA_W-1:0] = q.wdata;
		REG_CMD: begin
			rd_val[CMD_SP_LSB +: 2] = q.space;
			rd_val[CMD_WR_BIT] = q.wr;
			rd_val[CMD_VEC_BIT] = q.vec;
		end
		REG_STAT: begin
			rd_val[ST_BUSY_BIT] = (q.fsm != S_IDLE);
			rd_val[ST_GRANT_BIT] = (q.fsm == S_HOLD);
			rd_val[ST_KEEP_BIT] = q.kp_en;
		end
		REG_RDATA: rd_val[DATA_W-1:0] = q.rdata;
		default:   rd_val = '0;
		endcase
	end

	assign bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
	                {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign wmerge = (rd_val & ~bmask) | (avs_writedata & bmask);

	////////////////////////////////////////////////////////////////////
	always_comb begin
		d       = q;
		wr_take = avs_write && !q.avs_wait;
		start   = wr_take && (avs_address == REG_CMD);
		acc_d   = 1'b0;

		// one wait cycle, then the answer; write lands on that edge
		d.avs_wait = 1'b1;
		if ((avs_read || avs_write) && q.avs_wait) begin
			d.avs_wait = 1'b0;
			d.rbus = rd_val;
		end
		if (wr_take) begin
			case (avs_address)
			REG_BSC:   d.keep_en = wmerge[BSC_KEEP_BIT]; // RQ8
			REG_WAIT: begin
				// frozen while busy so an access never sees it change
				if (q.fsm == S_IDLE)
					d.ws_cfg = wmerge[WS_W-1:0];
			end
			REG_ADDR:  d.addr = wmerge[ADDR_W-1:0];
			REG_WDATA: d.wdata = wmerge[DATA_W-1:0];
			default: ;
			endcase
		end

		case (q.fsm)
		S_IDLE: begin
			if (!hold_s) begin
				d.fsm = S_HOLD; // RQ11
			end else if (start) begin
				// commands while busy or held are dropped
				d.fsm = S_ACC;
				d.ws_cnt = '0;
				d.vec = wmerge[CMD_VEC_BIT];
				d.space = wmerge[CMD_VEC_BIT] ? SP_PROG
				        : wmerge[CMD_SP_LSB +: 2];
				d.wr = wmerge[CMD_WR_BIT] && !wmerge[CMD_VEC_BIT];
			end
		end
		S_ACC: begin
			// two cycles plus the programmed wait states
			if (q.ws_cnt == WC_W'(q.ws_cfg) + WC_W'(1)) begin
				if (q.ws_cfg >= WS_READY_MIN)
					d.fsm = S_RDY; // RQ12
				else
					d.fsm = S_DONE;
			end else begin
				d.ws_cnt = q.ws_cnt + WC_W'(1);
			end
		end
		S_RDY: begin
			if (ready_s)
				d.fsm = S_DONE; // RQ12
		end
		S_DONE: begin
			// synchroniser lag: this is the pin two cycles back
			if (!q.wr)
				d.rdata = data_s; // RQ4
			d.fsm = S_IDLE;
		end
		S_HOLD: begin
			if (hold_s)
				d.fsm = S_IDLE;
		end
		default: d.fsm = S_IDLE;
		endcase

		// pins follow the next state so they line up with q.fsm
		acc_d = (d.fsm == S_ACC) || (d.fsm == S_RDY);
		d.alo = d.addr[LO_W-1:0]; // RQ1
		d.ahi = (d.space == SP_PROG) ? d.addr[ADDR_W-1:LO_W]
		      : '0; // RQ1
		d.ahi_oe = off_s && (d.fsm != S_HOLD); // RQ2 RQ15
		d.alo_oe = d.ahi_oe && !hw_s; // RQ3
		d.hp_addr = hw_s ? alo_s : q.hp_addr; // RQ3
		d.d_oe = off_s && hold_s && acc_d && d.wr; // RQ5 RQ6 RQ15
		d.keep_val = q.d_oe ? q.dout : data_s; // RQ7
		d.dout = d.d_oe ? d.wdata : d.keep_val; // RQ4 RQ7
		d.kp_en = d.keep_en && !d.d_oe; // RQ7
		d.rw_n = !(acc_d && d.wr); // RQ13
		d.memory_strobe_n_n = !(acc_d && (d.space != SP_IO)); // RQ14
		d.iostrb_n = !(acc_d && (d.space == SP_IO));
		d.ctl_oe = off_s && (d.fsm != S_HOLD); // RQ11 RQ15
		d.grant_n = (d.fsm != S_HOLD); // RQ11
		d.grant_oe = off_s; // RQ15
		d.interrupt_ack_n_n = !(acc_d && d.vec); // RQ9
		d.interrupt_ack_n_oe = off_s; // RQ10
	end

	////////////////////////////////////////////////////////////////////
	// reset leaves every driver off and keepers disabled
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0; // RQ5 RQ8
			q.fsm <= S_IDLE;
			q.ws_cfg <= WS_RST;
			q.avs_wait <= 1'b1;
			q.rw_n <= 1'b1;
			q.memory_strobe_n_n <= 1'b1;
			q.iostrb_n <= 1'b1;
			q.grant_n <= 1'b1;
			q.interrupt_ack_n_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign avs_readdata      = q.rbus;
	assign avs_waitrequest   = q.avs_wait;
	assign addr_lo_o         = q.alo;
	assign addr_lo_oe        = q.alo_oe;
	assign addr_hi_o         = q.ahi;
	assign addr_hi_oe        = q.ahi_oe;
	assign data_o            = q.dout;
	assign data_oe           = q.d_oe;
	assign bus_keeper_enable = q.kp_en;
	assign read_write_n      = q.rw_n;
	assign memory_strobe_n   = q.memory_strobe_n_n;
	assign io_strobe_n       = q.iostrb_n;
	assign ctl_oe            = q.ctl_oe;
	assign bus_grant_n       = q.grant_n;
	assign bus_grant_oe      = q.grant_oe;
	assign interrupt_ack_n   = q.interrupt_ack_n_n;
	assign interrupt_ack_oe  = q.interrupt_ack_n_oe;
	assign host_port_addr    = q.hp_addr;

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence rdy_wait_s;
		q.fsm == S_RDY && !ready_s;
	endsequence
	sequence rdy_stay_s;
		q.fsm == S_RDY && !memory_strobe_n ^ (q.space == SP_IO);
	endsequence
	sequence acc_short_s;
		q.fsm == S_ACC && q.ws_cfg < WS_READY_MIN;
	endsequence

	float_all_a: assert property (!off_s |=> !(addr_lo_oe || // RQ15
		addr_hi_oe || data_oe || ctl_oe || bus_grant_oe ||
		interrupt_ack_oe))
		else $error("output driven while float input low");
	hold_float_a: assert property (q.fsm == S_HOLD |-> // RQ11
		!addr_lo_oe && !addr_hi_oe && !data_oe && !ctl_oe &&
		!bus_grant_n)
		else $error("lines driven during hold grant");
	grant_take_a: assert property (q.fsm == S_IDLE && !hold_s // RQ2
		|=> !bus_grant_n && !addr_hi_oe)
		else $error("hold request not granted");
	data_hold_a: assert property (!hold_s |=> !data_oe) // RQ5
		else $error("data driven under hold request");
	rw_write_a: assert property (!read_write_n |-> q.wr && // RQ13
		(q.fsm == S_ACC || q.fsm == S_RDY))
		else $error("write direction outside a write");
	strobe_space_a: assert property (!memory_strobe_n |-> // RQ14
		q.space != SP_IO && io_strobe_n)
		else $error("memory strobe on io access");
	upper_prog_a: assert property (q.space != SP_PROG |-> // RQ1
		addr_hi_o == '0)
		else $error("upper address used off program space");
	host_input_a: assert property (hw_s |=> !addr_lo_oe) // RQ3
		else $error("low address driven in host mode");
	interrupt_ack_n_vec_a: assert property (!interrupt_ack_n |-> // RQ9
		q.vec && addr_lo_o == q.addr[LO_W-1:0] &&
		!memory_strobe_n)
		else $error("ack without vector on address");
	keeper_a: assert property (bus_keeper_enable |-> // RQ7
		!data_oe && q.keep_en)
		else $error("keeper active while driving");
	ready_wait_a: assert property (rdy_wait_s |=> rdy_stay_s) // RQ12
		else $error("left ready wait while not ready");
	ready_skip_a: assert property (acc_short_s |=> // RQ12
		q.fsm != S_RDY)
		else $error("ready sampled with few wait states");
	ready_done_a: assert property (q.fsm == S_RDY && ready_s |=> // RQ12
		q.fsm == S_DONE)
		else $error("ready seen but access not ended");
	io_space_a: assert property (!io_strobe_n |-> // RQ14
		q.space == SP_IO && memory_strobe_n)
		else $error("io strobe off io access");
	data_write_a: assert property (data_oe |-> // RQ4 RQ5
		!read_write_n && data_o == q.wdata)
		else $error("data driven outside a write");
	grant_release_a: assert property (q.fsm == S_HOLD && hold_s |=> // RQ11
		bus_grant_n)
		else $error("grant kept after hold request dropped");
	host_addr_a: assert property (hw_s |=> // RQ3
		host_port_addr == $past(alo_s))
		else $error("host address not taken from pins");
	interrupt_ack_n_float_a: assert property (!off_s |=> // RQ10
		!interrupt_ack_oe)
		else $error("interrupt ack driven while float low");

endmodule // ebp_bus

// ===== verilog/ebp_pkg.sv
// constants and types for the external bus pin controller
package ebp_pkg;

	localparam int ADDR_W = 23;
	localparam int LO_W   = 16;
	localparam int HI_W   = ADDR_W - LO_W;
	localparam int DATA_W = 16;
	localparam int WS_W   = 3;
	localparam int WC_W   = WS_W + 1;
	localparam int AV_AW  = 5;

	// register byte offsets
	localparam logic [AV_AW-1:0] REG_BSC   = 5'h00;
	localparam logic [AV_AW-1:0] REG_WAIT  = 5'h04;
	localparam logic [AV_AW-1:0] REG_ADDR  = 5'h08;
	localparam logic [AV_AW-1:0] REG_WDATA = 5'h0C;
	localparam logic [AV_AW-1:0] REG_CMD   = 5'h10;
	localparam logic [AV_AW-1:0] REG_STAT  = 5'h14;
	localparam logic [AV_AW-1:0] REG_RDATA = 5'h18;

	// field positions
	localparam int BSC_KEEP_BIT = 0;
	localparam int CMD_SP_LSB   = 0;
	localparam int CMD_WR_BIT   = 2;
	localparam int CMD_VEC_BIT  = 3;
	localparam int ST_BUSY_BIT  = 0;
	localparam int ST_GRANT_BIT = 1;
	localparam int ST_KEEP_BIT  = 2;

	// address spaces
	localparam logic [1:0] SP_PROG = 2'h0;
	localparam logic [1:0] SP_DATA = 2'h1;
	localparam logic [1:0] SP_IO   = 2'h2;

	// ready is looked at only from this many wait states upward
	localparam logic [WS_W-1:0] WS_READY_MIN = 3'h2;
	localparam logic [WS_W-1:0] WS_RST       = 3'h0;

	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_ACC  = 5'h02,
		S_RDY  = 5'h04,
		S_DONE = 5'h08,
		S_HOLD = 5'h10
	} ebp_fsm_t;

endpackage

// ===== verilog/ebp_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module ebp_sync #(
	parameter int           W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} ebp_sync_st_t;

	ebp_sync_st_t q;
	ebp_sync_st_t d;

	always_comb begin
		d    = q;
		d.s1 = din;
		d.s2 = q.s1;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q.s1 <= INIT;
			q.s2 <= INIT;
		end else begin
			q <= d;
		end
	end

	assign dout = q.s2;
endmodule // ebp_sync

// ===== verification/ebp_mem.sv
// external memory and i/o device model facing the bus pins
`timescale 1ns/1ns
module ebp_mem
	import ebp_pkg::*;
#(
	parameter int DLY = 4
) (
	input  wire logic              ref_clk,
	input  wire logic [LO_W-1:0]   addr_lo_o,
	input  wire logic              memory_strobe_n,
	input  wire logic              io_strobe_n,
	input  wire logic              read_write_n,
	input  wire logic              ctl_oe,
	input  wire logic              data_oe,
	input  wire logic [DATA_W-1:0] data_o,
	input  wire logic              bus_keeper_enable,
	input  wire logic              slow,
	output logic                   ready,
	output logic      [DATA_W-1:0] data_pin,
	output logic      [DATA_W-1:0] wr_last
);
	logic [DATA_W-1:0] last;
	int                cnt;
	logic              sel;
	assign sel = ctl_oe && !(memory_strobe_n && io_strobe_n);
	// undriven and unkept pins toggle so a stale level never passes
	assign data_pin = data_oe ? data_o :
		(sel && read_write_n) ? addr_lo_o ^ 16'h5A3C :
		bus_keeper_enable ? data_o : ~last;
	assign ready = slow ? (sel && cnt >= DLY) : 1'b1;
	always_ff @(posedge ref_clk) begin
		last <= data_pin;
		cnt <= sel ? cnt + 1 : 0;
		if (sel && !read_write_n && data_oe)
			wr_last <= data_pin;
	end
endmodule // ebp_mem

// ===== verification/ebp_bus_tb.sv
// self-checking bench for the external bus pin controller
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
	$display("wrong value at %0t: %h vs %h", $time, a, b); end end
module ebp_bus_tb;
	import ebp_pkg::*;
	logic ref_clk, rst_n, avs_read, avs_write, ready, float_all_n, slow;
	logic bus_hold_n, host_port_wide_select, avs_waitrequest, data_oe;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [15:0] addr_lo_i, addr_lo_o, data_o, data_pin, wr_last, hpa;
	logic [6:0] addr_hi_o;
	logic addr_lo_oe, addr_hi_oe, bke, rwn, msn, isn, ctl_oe, gn, goe;
	logic ian, iaoe;
	int bad_count, checks, s_cnt, n;
	logic s_mem, s_io, s_rw, s_interrupt_ack_n, in_acc;
	logic [5:0] oes;
	logic [6:0] s_hi;
	logic [15:0] s_lo;
	assign oes = {addr_lo_oe, addr_hi_oe, data_oe, ctl_oe, goe, iaoe};

	ebp_bus dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .addr_lo_i(addr_lo_i),
		.addr_lo_o(addr_lo_o), .addr_lo_oe(addr_lo_oe),
		.addr_hi_o(addr_hi_o), .addr_hi_oe(addr_hi_oe), .data_i(data_pin),
		.data_o(data_o), .data_oe(data_oe), .bus_keeper_enable(bke),
		.read_write_n(rwn), .memory_strobe_n(msn), .io_strobe_n(isn),
		.ctl_oe(ctl_oe), .bus_hold_n(bus_hold_n), .bus_grant_n(gn),
		.bus_grant_oe(goe), .ready(ready), .interrupt_ack_n(ian),
		.interrupt_ack_oe(iaoe), .float_all_n(float_all_n),
		.host_port_wide_select(host_port_wide_select),
		.host_port_addr(hpa));
	ebp_mem #(.DLY(4)) u_mem (.ref_clk(ref_clk), .addr_lo_o(addr_lo_o),
		.memory_strobe_n(msn), .io_strobe_n(isn), .read_write_n(rwn),
		.ctl_oe(ctl_oe), .data_oe(data_oe), .data_o(data_o),
		.bus_keeper_enable(bke), .slow(slow), .ready(ready),
		.data_pin(data_pin), .wr_last(wr_last));

	initial begin
		ref_clk = 0;
		forever #10 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////
	// strobe monitor: remembers pin values of the latest access
	always @(posedge ref_clk) begin
		if (!msn || !isn) begin
			if (!in_acc) begin
				s_cnt = 0;
				s_interrupt_ack_n = 1;
			end
			in_acc = 1;
			s_cnt++;
			s_mem = !msn;
			s_io = !isn;
			s_hi = addr_hi_o;
			s_lo = addr_lo_o;
			s_rw = rwn;
			s_interrupt_ack_n &= ian;
		end else
			in_acc = 0;
	end
	// the memory model answers a read with its address scrambled
	function automatic logic [15:0] exp_rd(input logic [15:0] a);
		return a ^ 16'h5A3C;
	endfunction
	task automatic end_sim();
		$display("mismatches %0d, comparisons %0d", bad_count, checks);
		if (bad_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic av(input bit wr, input logic [4:0] a,
			input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
		if (n >= 50) begin
			bad_count++;
			end_sim();
		end
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 100; i++) begin
			av(0, REG_STAT, 0);
			if (q[ST_BUSY_BIT] === 1'b0)
				return;
		end
		bad_count++;
		end_sim();
	endtask
	task automatic acc(logic [1:0] sp, bit wr, bit vec, logic [22:0] a,
			logic [15:0] d, logic [2:0] ws);
		bit rd_prog;
		rd_prog = vec || sp == SP_PROG;
		av(1, REG_WAIT, {29'h0, ws});
		av(1, REG_ADDR, {9'h0, a});
		av(1, REG_WDATA, {16'h0, d});
		// a stale count from the last access must not pass a lost one
		s_cnt = 0;
		av(1, REG_CMD, {28'h0, vec, wr, sp});
		wait_idle();
		av(0, REG_RDATA, 0);
		`CHK(s_mem, vec || sp != SP_IO)
		`CHK(s_io, !vec && sp == SP_IO)
		`CHK(s_lo, a[15:0])
		`CHK(s_hi, rd_prog ? a[22:16] : 7'h0)
		`CHK(s_rw, vec || !wr)
		`CHK(s_interrupt_ack_n, !vec)
		if (vec || !wr)
			`CHK(q[15:0], exp_rd(a[15:0]))
		else
			`CHK(wr_last, d)
		if (ws < 2)
			`CHK(s_cnt, ws + 2)
		else
			`CHK(s_cnt >= (slow ? 6 : ws + 2), 1'b1)
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		{rst_n, slow, host_port_wide_select, addr_lo_i} = '0;
		{float_all_n, bus_hold_n} = 2'b11;
		in_acc = 0;
		void'($urandom(93));
		repeat (7) @(posedge ref_clk);
		`CHK({data_oe, bke, ian}, 3'b001)
		@(posedge ref_clk);
		rst_n <= 1;
		repeat (3) @(posedge ref_clk);
		av(0, REG_BSC, 0);
		`CHK(q[BSC_KEEP_BIT], 1'b0)
		av(0, 5'h1C, 0);
		`CHK(q, 32'h0000_0000)
		for (int i = 0; i < 14; i++) begin
			slow <= (i == 0) ? 1'b1 : 1'($urandom);
			acc(2'($urandom % 3), 1'($urandom), i % 4 == 3, 23'($urandom),
				16'($urandom), (i == 0) ? 3'h3 : 3'($urandom % 4));
		end
		av(1, REG_BSC, 32'h0000_0001);
		acc(SP_DATA, 1, 0, 23'h00_1234, 16'hC3A5, 3'h0);
		repeat (4) @(posedge ref_clk);
		`CHK(data_pin, 16'hC3A5)
		av(0, REG_STAT, 0);
		`CHK(q[ST_KEEP_BIT], 1'b1)
		av(1, REG_BSC, 32'h0000_0000);
		av(0, REG_STAT, 0);
		`CHK(q[ST_KEEP_BIT], 1'b0)
		slow <= 1;
		av(1, REG_WAIT, 32'h0000_0003);
		av(1, REG_CMD, {28'h0, 4'b0100});
		float_all_n <= 0;
		repeat (4) @(posedge ref_clk);
		`CHK(oes, 6'h00)
		float_all_n <= 1;
		wait_idle();
		bus_hold_n <= 0;
		repeat (5) @(posedge ref_clk);
		`CHK({gn, oes[5:2]}, 5'h00)
		av(0, REG_STAT, 0);
		`CHK(q[ST_GRANT_BIT], 1'b1)
		bus_hold_n <= 1;
		repeat (5) @(posedge ref_clk);
		`CHK(gn, 1'b1)
		host_port_wide_select <= 1;
		addr_lo_i <= 16'($urandom);
		repeat (5) @(posedge ref_clk);
		`CHK(hpa, addr_lo_i)
		`CHK(addr_lo_oe, 1'b0)
		end_sim();
	end
endmodule // ebp_bus_tb
